// *** logic/foc_regs.svh ***
// constants of the field-oriented motor control core
`ifndef FOC_REGS_SVH
`define FOC_REGS_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define FOC_CLK_HZ        250000000
`define FOC_PWM_HZ        17500
`define FOC_HALF_TICKS    (`FOC_CLK_HZ / (2 * `FOC_PWM_HZ))

// ----------------------------------------------------------------------------
// fixed-point scaling
// ----------------------------------------------------------------------------
`define FOC_Q15_FRAC      15
`define FOC_Q15_ONE       19'sh08000
`define FOC_INV_SQRT3     18'sh049E7
`define FOC_ROT_GAIN_INV  18'sh04DBA
`define FOC_GAIN_SHIFT    8
`define FOC_ROT_ITER      14
`define FOC_TURN_HALF     16'h8000

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define FOC_INTEG_RESET   16'sh0000
`define FOC_SECTOR_RESET  3'h1

`endif

// *** logic/foc_pkg.sv ***
// types and saturation helper of the field-oriented motor control core
package foc_pkg;

	typedef logic signed [15:0] foc_q15_t;
	typedef logic [2:0]         foc_phase_t;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'h0,
		ST_CLARKE  = 4'h1,
		ST_PARK    = 4'h2,
		ST_PARK_W  = 4'h3,
		ST_PI      = 4'h4,
		ST_IPARK   = 4'h5,
		ST_IPARK_W = 4'h6,
		ST_PROJ    = 4'h7,
		ST_TIMES   = 4'h8,
		ST_DUTY    = 4'h9
	} foc_state_e;

	function automatic foc_q15_t foc_sat16(input logic signed [47:0] v);
		if (v > 48'sh0000_0000_7FFF) begin
			foc_sat16 = 16'sh7FFF;
		end else if (v < 48'shFFFF_FFFF_8000) begin
			foc_sat16 = 16'sh8000;
		end else begin
			foc_sat16 = v[15:0];
		end
	endfunction : foc_sat16

endpackage : foc_pkg

// *** logic/foc_rot_if.sv ***
// handshake between the control sequencer and the vector rotator
`timescale 1ns/100ps
interface foc_rot_if;
	logic              start;
	foc_pkg::foc_q15_t x_in;
	foc_pkg::foc_q15_t y_in;
	logic [15:0]       angle;
	logic              done;
	foc_pkg::foc_q15_t x_out;
	foc_pkg::foc_q15_t y_out;

	modport seq (output start, x_in, y_in, angle, input done, x_out, y_out);
	modport rot (input start, x_in, y_in, angle, output done, x_out, y_out);
endinterface : foc_rot_if

// *** logic/foc_rotator.sv ***
// iterative vector rotator, shared by the forward and inverse frame rotations
`timescale 1ns/100ps
`include "foc_regs.svh"
module foc_rotator #(
	parameter int ITER = `FOC_ROT_ITER,
	parameter int W    = 20
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// request and result
	foc_rot_if.rot   rb
);

	// ------------------------------------------------------------------------
	// arctangent steps, one full turn is 65536
	// ------------------------------------------------------------------------
	function automatic logic signed [16:0] atan_step(input logic [3:0] i);
		case (i)
			4'h0:    atan_step = 17'sh02000;
			4'h1:    atan_step = 17'sh012E4;
			4'h2:    atan_step = 17'sh009FB;
			4'h3:    atan_step = 17'sh00511;
			4'h4:    atan_step = 17'sh0028B;
			4'h5:    atan_step = 17'sh00146;
			4'h6:    atan_step = 17'sh000A3;
			4'h7:    atan_step = 17'sh00051;
			4'h8:    atan_step = 17'sh00029;
			4'h9:    atan_step = 17'sh00014;
			4'hA:    atan_step = 17'sh0000A;
			4'hB:    atan_step = 17'sh00005;
			4'hC:    atan_step = 17'sh00003;
			4'hD:    atan_step = 17'sh00001;
			4'hE:    atan_step = 17'sh00001;
			default: atan_step = 17'sh00000;
		endcase
	endfunction : atan_step

	logic signed [W-1:0]  x_reg;
	logic signed [W-1:0]  y_reg;
	logic signed [16:0]   z_reg;
	logic [3:0]           step_reg;
	logic                 busy_reg;
	logic                 fin_reg;
	logic                 done_reg;
	foc_pkg::foc_q15_t    xo_reg;
	foc_pkg::foc_q15_t    yo_reg;

	// ------------------------------------------------------------------------
	// pre-rotation by half a turn keeps the residual inside the converging range
	// ------------------------------------------------------------------------
	wire logic                flip    = rb.angle[15] ^ rb.angle[14];
	wire logic [15:0]         ang_adj = rb.angle + (flip ? `FOC_TURN_HALF : 16'h0000);
	wire logic signed [W-1:0] x_ext   = W'(rb.x_in);
	wire logic signed [W-1:0] y_ext   = W'(rb.y_in);
	wire logic                dir     = ~z_reg[16];
	wire logic signed [W-1:0] x_sh    = x_reg >>> step_reg;
	wire logic signed [W-1:0] y_sh    = y_reg >>> step_reg;
	wire logic signed [16:0]  at      = atan_step(step_reg);
	wire logic signed [W-1:0] x_next  = dir ? x_reg - y_sh : x_reg + y_sh;
	wire logic signed [W-1:0] y_next  = dir ? y_reg + x_sh : y_reg - x_sh;
	wire logic signed [16:0]  z_next  = dir ? z_reg - at : z_reg + at;
	wire logic                last    = step_reg == 4'(ITER - 1);
	wire logic signed [W+17:0] x_scl  = x_reg * `FOC_ROT_GAIN_INV;
	wire logic signed [W+17:0] y_scl  = y_reg * `FOC_ROT_GAIN_INV;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			x_reg    <= '0;
			y_reg    <= '0;
			z_reg    <= '0;
			step_reg <= 4'h0;
			busy_reg <= 1'b0;
		end else if (rb.start) begin
			x_reg    <= flip ? -x_ext : x_ext;
			y_reg    <= flip ? -y_ext : y_ext;
			z_reg    <= {ang_adj[15], ang_adj};
			step_reg <= 4'h0;
			busy_reg <= 1'b1;
		end else if (busy_reg) begin
			x_reg    <= x_next;
			y_reg    <= y_next;
			z_reg    <= z_next;
			step_reg <= step_reg + 4'h1;
			busy_reg <= !last;
		end
	end

	// gain compensation and saturation one cycle after the last step
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fin_reg  <= 1'b0;
			done_reg <= 1'b0;
			xo_reg   <= '0;
			yo_reg   <= '0;
		end else begin
			fin_reg  <= busy_reg && last && !rb.start;
			done_reg <= fin_reg;
			if (fin_reg) begin
				xo_reg <= foc_pkg::foc_sat16(48'(x_scl >>> `FOC_Q15_FRAC));
				yo_reg <= foc_pkg::foc_sat16(48'(y_scl >>> `FOC_Q15_FRAC));
			end
		end
	end

	assign rb.done  = done_reg;
	assign rb.x_out = xo_reg;
	assign rb.y_out = yo_reg;

endmodule : foc_rotator

// *** logic/foc_svpwm_core.sv ***
// field-oriented current control with seven-segment space-vector modulation
// Function
// RQ1: the two-axis current is built from phases a and b alone, phase c being their negated sum.
// RQ2: alpha equals phase a and beta equals phase a plus twice phase b over root three.
// RQ3: d is beta sine plus alpha cosine and q is beta cosine minus alpha sine of the rotor angle.
// RQ4: each rotating axis has its own proportional-integral loop from current to voltage.
// RQ5: alpha voltage is Vd cosine minus Vq sine and beta voltage is Vd sine plus Vq cosine.
// RQ6: every inverter branch has exactly one of its two switches on at all times.
// RQ7: states 111 and 000 are the zero vectors that put no voltage between phases.
// RQ8: a switching state is a three-bit word with one bit per phase, high switch for a one.
// RQ9: the reference is placed in one of six sectors, bounded by two vectors one bit apart.
// RQ10: each active on-time is a fraction of the period set by amplitude and angle in the sector.
// RQ11: the period left over after both active on-times is spent in zero vectors.
// RQ12: each period runs zero, first active, second active, all-ones, then the mirror order.
// RQ13: the all-ones vector sits in the middle so every segment change moves one branch only; branches with equal compares switch together.
// RQ14: lowest phase duty is half the zero time, middle adds the second time, highest the first.
// RQ15: new compare values wait in shadow registers and load only at the counter limit.
// RQ16: one full update runs per PWM period from the period-start strobe, ending in a valid pulse.
// RQ17: loop outputs and integrators saturate to the signed range so on-times fit the period.
`timescale 1ns/100ps
`include "foc_regs.svh"
module foc_svpwm_core #(
	parameter int HALF_TICKS = `FOC_HALF_TICKS
) (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// measured phase currents and rotor angle, one turn is 65536
	input wire logic [15:0] ia,
	input wire logic [15:0] ib,
	input wire logic [15:0] theta,
	// current set points and loop gains
	input wire logic [15:0] id_ref,
	input wire logic [15:0] iq_ref,
	input wire logic [15:0] kp,
	input wire logic [15:0] ki,
	// duty handoff, full period is 16'h8000
	output logic [15:0]     duty_a,
	output logic [15:0]     duty_b,
	output logic [15:0]     duty_c,
	output logic            duty_valid,
	output logic [2:0]      sector,
	output logic            period_start,
	// inverter bridge switches, bit 2 is phase a
	output logic [2:0]      gate_hi,
	output logic [2:0]      gate_lo
);

	localparam int CW = $clog2(HALF_TICKS + 1);
	localparam logic [CW-1:0] HALF_C = CW'(HALF_TICKS);

	// ------------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------------
	foc_pkg::foc_state_e state_reg;
	foc_pkg::foc_state_e state_next;
	foc_rot_if           rot_bus ();

	logic                period_start_reg;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			foc_pkg::ST_IDLE:    if (period_start_reg) state_next = foc_pkg::ST_CLARKE; // RQ16
			foc_pkg::ST_CLARKE:  state_next = foc_pkg::ST_PARK;
			foc_pkg::ST_PARK:    state_next = foc_pkg::ST_PARK_W;
			foc_pkg::ST_PARK_W:  if (rot_bus.done) state_next = foc_pkg::ST_PI;
			foc_pkg::ST_PI:      state_next = foc_pkg::ST_IPARK;
			foc_pkg::ST_IPARK:   state_next = foc_pkg::ST_IPARK_W;
			foc_pkg::ST_IPARK_W: if (rot_bus.done) state_next = foc_pkg::ST_PROJ;
			foc_pkg::ST_PROJ:    state_next = foc_pkg::ST_TIMES;
			foc_pkg::ST_TIMES:   state_next = foc_pkg::ST_DUTY;
			foc_pkg::ST_DUTY:    state_next = foc_pkg::ST_IDLE;
			default:             state_next = foc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg <= foc_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------------------
	// sampling and stationary frame
	// ------------------------------------------------------------------------
	foc_pkg::foc_q15_t ia_reg;
	foc_pkg::foc_q15_t ib_reg;
	logic [15:0]       theta_reg;
	foc_pkg::foc_q15_t alpha_reg;
	foc_pkg::foc_q15_t beta_reg;

	// phase c is never read: the three currents sum to zero
	wire logic signed [17:0] ab_sum   = 18'(ia_reg) + 18'(ib_reg) + 18'(ib_reg); // RQ1
	wire logic signed [35:0] beta_prd = ab_sum * `FOC_INV_SQRT3;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ia_reg    <= '0;
			ib_reg    <= '0;
			theta_reg <= 16'h0000;
			alpha_reg <= '0;
			beta_reg  <= '0;
		end else if (state_reg == foc_pkg::ST_IDLE && period_start_reg) begin
			ia_reg    <= ia;
			ib_reg    <= ib;
			theta_reg <= theta;
		end else if (state_reg == foc_pkg::ST_CLARKE) begin
			alpha_reg <= ia_reg; // RQ2
			beta_reg  <= foc_pkg::foc_sat16(48'(beta_prd >>> `FOC_Q15_FRAC)); // RQ2
		end
	end

	// ------------------------------------------------------------------------
	// frame rotations share one rotator
	// ------------------------------------------------------------------------
	foc_pkg::foc_q15_t id_reg;
	foc_pkg::foc_q15_t iq_reg;
	foc_pkg::foc_q15_t va_reg;
	foc_pkg::foc_q15_t vb_reg;
	foc_pkg::foc_q15_t v_reg [2];

	wire logic in_park = state_reg == foc_pkg::ST_PARK;
	// forward rotation by minus theta gives d and q
	assign rot_bus.start = in_park || state_reg == foc_pkg::ST_IPARK; // RQ3 RQ5
	assign rot_bus.x_in  = in_park ? alpha_reg : v_reg[0];
	assign rot_bus.y_in  = in_park ? beta_reg : v_reg[1];
	assign rot_bus.angle = in_park ? 16'h0000 - theta_reg : theta_reg; // RQ3 RQ5

	foc_rotator #(
		.ITER (`FOC_ROT_ITER),
		.W    (20)
	) u_rot (
		.mclk (mclk),
		.rst  (rst),
		.rb   (rot_bus.rot)
	);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			id_reg <= '0;
			iq_reg <= '0;
			va_reg <= '0;
			vb_reg <= '0;
		end else if (rot_bus.done && state_reg == foc_pkg::ST_PARK_W) begin
			id_reg <= rot_bus.x_out; // RQ3
			iq_reg <= rot_bus.y_out; // RQ3
		end else if (rot_bus.done && state_reg == foc_pkg::ST_IPARK_W) begin
			va_reg <= rot_bus.x_out; // RQ5
			vb_reg <= rot_bus.y_out; // RQ5
		end
	end

	// ------------------------------------------------------------------------
	// per-axis regulators, axis 0 is d and axis 1 is q
	// ------------------------------------------------------------------------
	foc_pkg::foc_q15_t integ_reg [2];
	wire logic signed [16:0] kp_s = {1'b0, kp};
	wire logic signed [16:0] ki_s = {1'b0, ki};

	for (genvar a = 0; a < 2; a++) begin : g_pi
		wire logic signed [16:0] err    = (a == 0) ? 17'($signed(id_ref)) - 17'(id_reg)
		                                           : 17'($signed(iq_ref)) - 17'(iq_reg);
		wire logic signed [33:0] p_prd  = err * kp_s;
		wire logic signed [33:0] i_prd  = err * ki_s;
		wire logic signed [34:0] i_sum  = 35'(integ_reg[a]) + 35'(i_prd >>> `FOC_GAIN_SHIFT);
		// integrator clamps on its own so it cannot wind up past the output range
		wire foc_pkg::foc_q15_t  i_next = foc_pkg::foc_sat16(48'(i_sum)); // RQ17
		wire logic signed [34:0] v_sum  = 35'(p_prd >>> `FOC_GAIN_SHIFT) + 35'(i_next);

		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				integ_reg[a] <= `FOC_INTEG_RESET;
				v_reg[a]     <= '0;
			end else if (state_reg == foc_pkg::ST_PI) begin
				integ_reg[a] <= i_next; // RQ4
				v_reg[a]     <= foc_pkg::foc_sat16(48'(v_sum)); // RQ4 RQ17
			end
		end
	end

	// ------------------------------------------------------------------------
	// sector and on-times
	// ------------------------------------------------------------------------
	logic signed [18:0] u1_reg;
	logic signed [18:0] u2_reg;
	logic signed [18:0] u3_reg;

	// u values are the reference projected on the three bound axes
	wire logic signed [33:0] vb_prd = vb_reg * `FOC_INV_SQRT3;
	wire logic signed [18:0] vb_div = 19'(vb_prd >>> `FOC_Q15_FRAC);
	wire logic signed [18:0] va_ext = 19'(va_reg);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			u1_reg <= '0;
			u2_reg <= '0;
			u3_reg <= '0;
		end else if (state_reg == foc_pkg::ST_PROJ) begin
			u1_reg <= vb_div + vb_div;
			u2_reg <= va_ext - vb_div;
			u3_reg <= -va_ext - vb_div;
		end
	end

	logic signed [18:0] tf_raw;
	logic signed [18:0] ts_raw;
	logic [2:0]         sec_next;
	logic [1:0]         hi_ph;
	logic [1:0]         mid_ph;
	logic [1:0]         lo_ph;

	// first vector has one bit set, second has two; phase index 2 is a
	wire logic [2:0] sgn = {~u3_reg[18], ~u2_reg[18], ~u1_reg[18]};
	always_comb begin
		tf_raw   = '0;
		ts_raw   = '0;
		sec_next = `FOC_SECTOR_RESET;
		hi_ph    = 2'h2;
		mid_ph   = 2'h1;
		lo_ph    = 2'h0;
		case (sgn) // RQ9 RQ10
			3'b011: begin
				tf_raw = u2_reg;  ts_raw = u1_reg;  sec_next = 3'h1;
			end
			3'b001: begin
				tf_raw = -u2_reg; ts_raw = -u3_reg; sec_next = 3'h2;
				hi_ph = 2'h1; mid_ph = 2'h2; lo_ph = 2'h0;
			end
			3'b101: begin
				tf_raw = u1_reg;  ts_raw = u3_reg;  sec_next = 3'h3;
				hi_ph = 2'h1; mid_ph = 2'h0; lo_ph = 2'h2;
			end
			3'b100: begin
				tf_raw = -u1_reg; ts_raw = -u2_reg; sec_next = 3'h4;
				hi_ph = 2'h0; mid_ph = 2'h1; lo_ph = 2'h2;
			end
			3'b110: begin
				tf_raw = u3_reg;  ts_raw = u2_reg;  sec_next = 3'h5;
				hi_ph = 2'h0; mid_ph = 2'h2; lo_ph = 2'h1;
			end
			3'b010: begin
				tf_raw = -u3_reg; ts_raw = -u1_reg; sec_next = 3'h6;
				hi_ph = 2'h2; mid_ph = 2'h0; lo_ph = 2'h1;
			end
			default: begin
				tf_raw = '0;      ts_raw = '0;
			end
		endcase
	end

	// over-modulation trims the second time so the sum never passes one period
	wire logic signed [18:0] tf_c   = tf_raw[18] ? '0 :
	                                  (tf_raw > `FOC_Q15_ONE) ? `FOC_Q15_ONE : tf_raw; // RQ17
	wire logic signed [18:0] ts_max = `FOC_Q15_ONE - tf_c;
	wire logic signed [18:0] ts_c   = ts_raw[18] ? '0 : (ts_raw > ts_max) ? ts_max : ts_raw;

	logic signed [18:0] tf_reg;
	logic signed [18:0] ts_reg;
	logic [1:0]         hi_reg;
	logic [1:0]         mid_reg;
	logic [1:0]         lo_reg;
	logic [2:0]         sector_reg;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tf_reg     <= '0;
			ts_reg     <= '0;
			hi_reg     <= 2'h2;
			mid_reg    <= 2'h1;
			lo_reg     <= 2'h0;
			sector_reg <= `FOC_SECTOR_RESET;
		end else if (state_reg == foc_pkg::ST_TIMES) begin
			tf_reg     <= tf_c;
			ts_reg     <= ts_c;
			hi_reg     <= hi_ph;
			mid_reg    <= mid_ph;
			lo_reg     <= lo_ph;
			sector_reg <= sec_next; // RQ9
		end
	end

	// ------------------------------------------------------------------------
	// duty cycles and centre-aligned pattern
	// ------------------------------------------------------------------------
	wire logic signed [18:0] t_zero = `FOC_Q15_ONE - tf_reg - ts_reg; // RQ11
	wire logic signed [18:0] d_low  = t_zero >>> 1; // RQ14
	wire logic signed [18:0] d_mid  = d_low + ts_reg; // RQ14
	wire logic signed [18:0] d_high = d_mid + tf_reg; // RQ14

	logic [CW-1:0] cnt_reg;
	logic          up_reg;
	logic          valid_reg;
	logic [15:0]   duty_reg   [3];
	logic [CW-1:0] cmp_sh_reg [3];
	logic [CW-1:0] cmp_reg    [3];
	logic          hi_q       [3];
	logic          lo_q       [3];

	// counter runs 0 up to HALF and back, one PWM period per round trip
	wire logic at_top = up_reg && cnt_reg == HALF_C - CW'(1);
	wire logic at_bot = !up_reg && cnt_reg == CW'(1);

	for (genvar p = 0; p < 3; p++) begin : g_ph
		wire logic [18:0]   d_sel = (hi_reg == 2'(p)) ? d_high :
		                            (mid_reg == 2'(p)) ? d_mid : d_low;
		wire logic [15:0]   d_u   = d_sel[15:0];
		wire logic [47:0]   c_prd = 48'(d_u) * 48'(HALF_TICKS);
		wire logic [CW-1:0] c_new = CW'(c_prd >> `FOC_Q15_FRAC);
		// high switch on near the counter top: zero vector 000 at both ends,
		// 111 in the middle, each edge moves one branch, or every branch whose compare is equal to it
		wire logic          on    = (cmp_reg[p] >= HALF_C) ||
		                            (cnt_reg > HALF_C - cmp_reg[p]); // RQ12 RQ13 RQ7

		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				duty_reg[p]   <= 16'h0000;
				cmp_sh_reg[p] <= '0;
				cmp_reg[p]    <= '0;
				hi_q[p]       <= 1'b0;
				lo_q[p]       <= 1'b1;
			end else begin
				if (state_reg == foc_pkg::ST_DUTY) begin
					duty_reg[p]   <= d_u;
					cmp_sh_reg[p] <= c_new;
				end
				if (at_bot) begin
					cmp_reg[p] <= cmp_sh_reg[p]; // RQ15
				end
				hi_q[p] <= on; // RQ8
				lo_q[p] <= !on; // RQ6
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_reg          <= '0;
			up_reg           <= 1'b1;
			period_start_reg <= 1'b0;
			valid_reg        <= 1'b0;
		end else begin
			cnt_reg          <= up_reg ? cnt_reg + CW'(1) : cnt_reg - CW'(1);
			up_reg           <= at_top ? 1'b0 : (at_bot ? 1'b1 : up_reg);
			period_start_reg <= at_bot; // RQ16
			valid_reg        <= state_reg == foc_pkg::ST_DUTY; // RQ16
		end
	end

	assign duty_a       = duty_reg[2];
	assign duty_b       = duty_reg[1];
	assign duty_c       = duty_reg[0];
	assign duty_valid   = valid_reg;
	assign sector       = sector_reg;
	assign period_start = period_start_reg;
	assign gate_hi      = {hi_q[2], hi_q[1], hi_q[0]};
	assign gate_lo      = {lo_q[2], lo_q[1], lo_q[0]};

endmodule : foc_svpwm_core

// *** verification/foc_bridge_model.sv ***
// behavioural inverter bridge: phase on-time per period and shoot-through watch
`timescale 1ns/100ps
module foc_bridge_model (
	// clock, reset and period marker
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        period_start,
	// switch drive, bit 2 is phase a
	input wire logic [2:0]  gate_hi,
	input wire logic [2:0]  gate_lo,
	// high-side cycles of the last whole period
	output logic     [15:0] on_a,
	output logic     [15:0] on_b,
	output logic     [15:0] on_c,
	output logic            shorted
);
	logic [15:0] acc [3];

	initial shorted = 1'b0;
	always @(posedge mclk) begin
		for (int p = 0; p < 3; p++) begin
			// equal levels mean a shorted or floating branch
			// switches are unknown until the first reset edge
			if (!rst && gate_hi[p] === gate_lo[p]) begin
				shorted <= 1'b1;
			end
			acc[p] <= period_start ? 16'(gate_hi[p]) : acc[p] + 16'(gate_hi[p]);
		end
		// totals move only at the counter limit
		if (period_start) begin
			{on_a, on_b, on_c} <= {acc[2], acc[1], acc[0]};
		end
	end
endmodule : foc_bridge_model

// *** verification/foc_svpwm_properties.sv ***
// concurrent checks on the ports of the motor control core
`timescale 1ns/100ps
module foc_svpwm_properties #(
	parameter int HALF_TICKS = 64
) (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// duty handoff
	input wire logic [15:0] duty_a,
	input wire logic [15:0] duty_b,
	input wire logic [15:0] duty_c,
	input wire logic        duty_valid,
	input wire logic [2:0]  sector,
	input wire logic        period_start,
	// bridge switches
	input wire logic [2:0]  gate_hi,
	input wire logic [2:0]  gate_lo
);
	logic [15:0] hi_w;
	logic [15:0] lo_w;
	logic [16:0] sum_w;
	logic [15:0] gap_reg;
	logic        seen_reg;
	logic        tie_reg;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	assign hi_w = (duty_a > duty_b) ? ((duty_a > duty_c) ? duty_a : duty_c)
		: ((duty_b > duty_c) ? duty_b : duty_c);
	assign lo_w = (duty_a < duty_b) ? ((duty_a < duty_c) ? duty_a : duty_c)
		: ((duty_b < duty_c) ? duty_b : duty_c);
	assign sum_w = {1'b0, hi_w} + {1'b0, lo_w};

	// compares as the core scales them; equal ones move their branches together
	wire logic [31:0] cmp_a = (32'(duty_a) * 32'(HALF_TICKS)) >> 15;
	wire logic [31:0] cmp_b = (32'(duty_b) * 32'(HALF_TICKS)) >> 15;
	wire logic [31:0] cmp_c = (32'(duty_c) * 32'(HALF_TICKS)) >> 15;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			gap_reg <= 16'h0;
			seen_reg <= 1'b0;
			tie_reg <= 1'b1;
		end else begin
			gap_reg <= period_start ? 16'h1 : gap_reg + 16'h1;
			seen_reg <= seen_reg | period_start;
			if (period_start) begin
				tie_reg <= cmp_a == cmp_b || cmp_b == cmp_c || cmp_a == cmp_c;
			end
		end
	end

	gates_paired_a: assert property (gate_lo == ~gate_hi)
		else $error("gate pair not complementary");
	one_branch_a: assert property ($countones(gate_hi ^ $past(gate_hi)) <= 1
		|| tie_reg && ((((gate_hi ^ $past(gate_hi)) & gate_hi) == 3'h0)
		|| (((gate_hi ^ $past(gate_hi)) & ~gate_hi) == 3'h0)))
		else $error("more than one branch switched");
	valid_pulse_a: assert property (duty_valid |=> !duty_valid)
		else $error("duty valid longer than a cycle");
	update_latency_a: assert property (period_start |-> ##[20:60] duty_valid)
		else $error("no update after period start");
	duty_hold_a: assert property (!duty_valid |-> $stable({duty_a, duty_b, duty_c}))
		else $error("duties moved without valid");
	sector_legal_a: assert property (duty_valid |-> sector inside {[3'h1:3'h6]})
		else $error("sector out of range");
	zero_split_a: assert property (duty_valid |-> sum_w inside {[17'h07FFE:17'h08000]})
		else $error("zero time not split evenly");
	sector_order_a: assert property (duty_valid && sector == 3'h1
		|-> duty_a >= duty_b && duty_b >= duty_c)
		else $error("phase order wrong in first sector");
	period_span_a: assert property (period_start && seen_reg
		|-> gap_reg == 16'(2 * HALF_TICKS))
		else $error("period length wrong");
endmodule : foc_svpwm_properties

bind foc_svpwm_core foc_svpwm_properties #(.HALF_TICKS(HALF_TICKS)) chk_u (.mclk(mclk),
	.rst(rst), .duty_a(duty_a), .duty_b(duty_b), .duty_c(duty_c), .duty_valid(duty_valid),
	.sector(sector), .period_start(period_start), .gate_hi(gate_hi), .gate_lo(gate_lo));

// *** verification/foc_svpwm_core_bench.sv ***
// self-checking bench of the motor control core
`timescale 1ns/100ps
module foc_svpwm_core_bench;
	localparam int HALF = 64;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] ia = '0, ib = '0, theta = '0, id_ref = '0, iq_ref = '0, kp = '0, ki = '0;
	logic [15:0] duty_a, duty_b, duty_c, on_a, on_b, on_c;
	logic [2:0]  sector, gate_hi, gate_lo;
	logic        duty_valid, period_start, shorted;
	int          fails = 0;
	int          check_count = 0;

	always #2 mclk = ~mclk;

	foc_svpwm_core #(.HALF_TICKS(HALF)) dut_u (.mclk(mclk), .rst(rst), .ia(ia), .ib(ib),
		.theta(theta), .id_ref(id_ref), .iq_ref(iq_ref), .kp(kp), .ki(ki), .duty_a(duty_a),
		.duty_b(duty_b), .duty_c(duty_c), .duty_valid(duty_valid), .sector(sector),
		.period_start(period_start), .gate_hi(gate_hi), .gate_lo(gate_lo));
	foc_bridge_model br_u (.mclk(mclk), .rst(rst), .period_start(period_start),
		.gate_hi(gate_hi), .gate_lo(gate_lo), .on_a(on_a), .on_b(on_b), .on_c(on_c),
		.shorted(shorted));

	task automatic stop_test;
		if (fails == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input int tol);
		int d;
		check_count++;
		d = int'(seen) - int'(exp);
		if ($isunknown(seen) || d > tol || d < -tol) begin
			fails++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask : check

	// sel high waits for period start, low for a duty update
	task automatic wait_for(input bit sel);
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while ((sel ? period_start : duty_valid) !== 1'b1 && n < 1000);
		if (n >= 1000) begin
			fails++;
			stop_test;
		end
	endtask : wait_for

	// second update is the first one computed wholly from the new inputs
	task automatic apply(input logic [15:0] a, b, t, d, q, p, i);
		@(posedge mclk);
		#1;
		{ia, ib, theta, id_ref, iq_ref, kp, ki} = {a, b, t, d, q, p, i};
		wait_for(1'b0);
		wait_for(1'b0);
	endtask : apply

	task automatic judge(input logic [2:0] es, input logic [15:0] ea, eb, ec, input int tol);
		check({13'h0, sector}, {13'h0, es}, 0);
		check(duty_a, ea, tol);
		check(duty_b, eb, tol);
		check(duty_c, ec, tol);
		wait_for(1'b1);
		wait_for(1'b1);
		// the model hands its totals over one edge after the strobe
		@(posedge mclk);
		#1;
		check(on_a, {8'h0, ea[15:9], 1'b0}, 3);
		check(on_b, {8'h0, eb[15:9], 1'b0}, 3);
		check(on_c, {8'h0, ec[15:9], 1'b0}, 3);
		check({15'h0, shorted}, 16'h0, 0);
	endtask : judge

	task automatic test_zero_ref;
		apply(16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
		judge(3'h1, 16'h4000, 16'h4000, 16'h4000, 2);
	endtask : test_zero_ref

	// currents give alpha 3000, beta 1000 on the voltage side
	task automatic test_current_path;
		apply(16'hD000, 16'h0A25, 16'h0, 16'h0, 16'h0, 16'h0100, 16'h0);
		judge(3'h1, 16'h5C9E, 16'h35DB, 16'h2361, 64);
	endtask : test_current_path

	task automatic test_voltage_path;
		apply(16'h0, 16'h0, 16'h4000, 16'h1000, 16'hD000, 16'h0100, 16'h0);
		judge(3'h1, 16'h5C9E, 16'h35DB, 16'h2361, 64);
	endtask : test_voltage_path

	// same reference turned half a turn: sector 4, phase c on longest
	task automatic test_far_sector;
		apply(16'h0, 16'h0, 16'hC000, 16'h1000, 16'hD000, 16'h0100, 16'h0);
		judge(3'h4, 16'h2361, 16'h4A26, 16'h5C9E, 64);
	endtask : test_far_sector

	// integrators run into the limit: over-modulated, no zero time left
	task automatic test_saturation;
		apply(16'h0, 16'h0, 16'h0, 16'h1000, 16'h0800, 16'h0, 16'h0100);
		repeat (20) wait_for(1'b0);
		judge(3'h1, 16'h8000, 16'h49E7, 16'h0000, 64);
	endtask : test_saturation

	initial begin
		repeat (4) @(posedge mclk);
		#1;
		rst = 1'b0;
		check({10'h0, gate_hi, gate_lo}, 16'h7, 0);
		test_zero_ref;
		test_current_path;
		test_voltage_path;
		test_far_sector;
		test_saturation;
		stop_test;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		stop_test;
	end
endmodule : foc_svpwm_core_bench
